// ---- logic/msgq_regs.svh ----
// Purpose: offsets, field positions and reset values of the message queue unit
// Assumes: 32-bit register words, byte offsets on the register bus
// Notes: definitions only
`ifndef MSGQ_REGS_SVH
`define MSGQ_REGS_SVH
// register bus byte offsets
`define MQ_CTRL_OFS 8'h00
`define MQ_STAT_OFS 8'h04
`define MQ_PTR_OFS 8'h10
// control fields
`define MQ_CTRL_EN 0
`define MQ_CTRL_DIS 1
`define MQ_CTRL_IPN_EN 2
`define MQ_CTRL_OP_EN 3
`define MQ_CTRL_SIZE_LSB 4
`define MQ_CTRL_SIZE_MSB 6
`define MQ_CTRL_BASE_LSB 20
`define MQ_CTRL_RST 32'h0000_0002
// status fields
`define MQ_STAT_EMPTY_LSB 0
`define MQ_STAT_FULL_LSB 4
`define MQ_STAT_IPN 8
`define MQ_STAT_OPP 9
// offsets inside the untranslated 4 Kbyte block of the messaging window
`define MQ_PORT_IN 12'h040
`define MQ_PORT_OUT 12'h044
`define MQ_SYSINT0 12'h030
`define MQ_SYSINT1 12'h034
// configuration space base register offsets
`define MQ_CFG_BAR0 8'h10
`define MQ_CFG_BAR2 8'h18
`define MQ_CFG_NONE 8'h00
`define MQ_EMPTY_DATA 32'hffff_ffff
`define MQ_QBYTES_MIN 20'h00400
`define MQ_PTR_STEP 20'h00004
`define MQ_RESP_OKAY 2'b00
`define MQ_RESP_SLVERR 2'b10
`endif

// ---- logic/msgq_pkg.sv ----
// Purpose: types shared by the message queue unit
// Assumes: nothing
// Notes: queue codes index the pointer arrays
package msgq_pkg;
   typedef enum logic [1:0] {
      Q_IN_FREE = 2'b00,
      Q_IN_POST = 2'b01,
      Q_OUT_POST = 2'b10,
      Q_OUT_FREE = 2'b11
   } queue_t;
   typedef enum logic [1:0] {
      PS_IDLE = 2'b00,
      PS_LB = 2'b01,
      PS_RSP = 2'b10
   } port_state_t;
   typedef enum logic [1:0] {
      LB_IDLE = 2'b00,
      LB_REQ = 2'b01,
      LB_WAIT = 2'b10
   } lb_state_t;
endpackage : msgq_pkg

// ---- logic/queue_ptr_step.sv ----
// Purpose: next value of a queue pointer, one entry on, wrapped to the queue
// Assumes: queue start aligned to its size
// Notes: size is 1 Kbyte shifted left by size_sel
`timescale 1ns/100ps
`include "msgq_regs.svh"
module queue_ptr_step (
   input wire logic [19:0] ptr,
   input wire logic [2:0] size_sel,
   output logic [19:0] next_ptr
);
   logic [19:0] mask;
   logic [19:0] inc;
   assign mask = (`MQ_QBYTES_MIN << size_sel) - 20'h00001;
   assign inc = ptr + `MQ_PTR_STEP;
   // upper bits keep the queue's slot, low bits wrap
   assign next_ptr = (ptr & ~mask) | (inc & mask);
endmodule : queue_ptr_step

// ---- logic/lb_cycle.sv ----
// Purpose: one local bus cycle at a time, read or write
// Assumes: the bus answers every taken request with one rsp_valid pulse
// Notes: request held until ready, then waits for the answer
`timescale 1ns/100ps
module lb_cycle import msgq_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input wire logic write,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   output logic lb_req_valid,
   input wire logic lb_req_ready,
   output logic lb_req_write,
   output logic [31:0] lb_req_addr,
   output logic [31:0] lb_req_wdata,
   input wire logic lb_rsp_valid,
   output logic done
);
   lb_state_t st;
   assign lb_req_valid = (st == LB_REQ);
   assign done = (st == LB_WAIT) && lb_rsp_valid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= LB_IDLE;
      end else begin
         unique case (st)
            LB_IDLE: if (start) st <= LB_REQ;
            LB_REQ: if (lb_req_ready) st <= LB_WAIT;
            LB_WAIT: if (lb_rsp_valid) st <= LB_IDLE;
            default: st <= LB_IDLE;
         endcase
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lb_req_write <= 1'b0;
         lb_req_addr <= 32'h0000_0000;
         lb_req_wdata <= 32'h0000_0000;
      end else if (start && st == LB_IDLE) begin
         lb_req_write <= write;
         lb_req_addr <= addr;
         lb_req_wdata <= wdata;
      end
   end
endmodule : lb_cycle

// ---- logic/msgq_unit.sv ----
// Purpose: message frame address queue unit between PCI ports and local memory
// Assumes: PCI port requests and local bus on aclk; registers over AXI4-Lite
// Notes: one PCI port request in service at a time
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "msgq_regs.svh"
// Notes on behaviour
// - four queues: in free, in post, out post, out free
// - top and bottom offset pointer per queue
// - write appends at top, read removes bottom
// - inbound port write posts, local interrupt if enabled
// - inbound port read pops free queue, empty all ones
// - outbound port read pops post queue, empty all ones
// - outbound port write stores to out free top
// - PCI interrupt when out post holds entries, if enabled
// - messaging enable moves register base to 0x018
// - low 4K: 0x030/0x034 interrupts, 0x040/0x044 ports
// - equal pointers mean empty; full by advancing top
// - device advances wrap modulo queue size
// - no top advance when full, no bottom when empty
// - port read: delayed local read, then advance bottom
// - inbound post status set on fire, write one clears
module msgq_unit import msgq_pkg::*; #(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pci_req_valid,
   output logic pci_req_ready,
   input wire logic pci_req_write,
   input wire logic [11:0] pci_req_offset,
   input wire logic [31:0] pci_req_wdata,
   output logic pci_rsp_valid,
   output logic [31:0] pci_rsp_rdata,
   output logic [1:0] sys_int_pulse,
   output logic pci_irq,
   output logic lb_irq,
   output logic [7:0] window_bar_cfg_offset,
   output logic [7:0] register_bar_cfg_offset,
   output logic lb_req_valid,
   input wire logic lb_req_ready,
   output logic lb_req_write,
   output logic [31:0] lb_req_addr,
   output logic [31:0] lb_req_wdata,
   input wire logic lb_rsp_valid,
   input wire logic [31:0] lb_rsp_rdata
);
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 8 and 32");
   end

   logic [31:0] ctrl;
   logic [19:0] top_ptr [4];
   logic [19:0] bot_ptr [4];
   logic [19:0] top_next [4];
   logic [19:0] bot_next [4];
   logic [3:0] full;
   logic [3:0] empty;
   logic ipn_status;
   logic msg_en, pci_access_disable, ipn_en, op_en;
   logic [2:0] size_sel;
   logic [11:0] base;
   logic [19:0] qmask;

   assign msg_en = ctrl[`MQ_CTRL_EN];
   assign pci_access_disable = ctrl[`MQ_CTRL_DIS];
   assign ipn_en = ctrl[`MQ_CTRL_IPN_EN];
   assign op_en = ctrl[`MQ_CTRL_OP_EN];
   assign size_sel = ctrl[`MQ_CTRL_SIZE_MSB:`MQ_CTRL_SIZE_LSB];
   assign base = ctrl[31:`MQ_CTRL_BASE_LSB];
   assign qmask = (`MQ_QBYTES_MIN << size_sel) - 20'h00001;

   // register bus write side
   logic wr_fire, ar_fire;
   logic [ADDR_W-3:0] waddr, raddr;
   logic wr_ctrl, wr_stat, wr_ptr;
   logic [2:0] wr_pidx, rd_pidx;
   logic [31:0] ptr_wval;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) res[i*8 +: 8] = val[i*8 +: 8];
      end
      return res;
   endfunction : merge

   function automatic logic is_ptr(input logic [ADDR_W-3:0] a);
      return a >= (ADDR_W-2)'(`MQ_PTR_OFS >> 2) && a < (ADDR_W-2)'((`MQ_PTR_OFS >> 2) + 8);
   endfunction : is_ptr

   assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_fire;
   assign s_axi_wready = wr_fire;
   assign waddr = s_axi_awaddr[ADDR_W-1:2];
   assign raddr = s_axi_araddr[ADDR_W-1:2];
   assign wr_ctrl = wr_fire && waddr == (ADDR_W-2)'(`MQ_CTRL_OFS >> 2);
   assign wr_stat = wr_fire && waddr == (ADDR_W-2)'(`MQ_STAT_OFS >> 2);
   assign wr_ptr = wr_fire && is_ptr(waddr);
   // pointer words 4..11 map to index 0..7
   assign wr_pidx = {~waddr[2], waddr[1:0]};
   assign rd_pidx = {~raddr[2], raddr[1:0]};
   assign ptr_wval = merge({base, wr_pidx[0] ? top_ptr[wr_pidx[2:1]] : bot_ptr[wr_pidx[2:1]]},
                           s_axi_wdata, s_axi_wstrb);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MQ_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_ctrl || wr_stat || wr_ptr) ? `MQ_RESP_OKAY : `MQ_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= `MQ_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl <= merge(ctrl, s_axi_wdata, s_axi_wstrb) & 32'hfff0_007f;
      end
   end

   // register bus read side
   assign ar_fire = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `MQ_RESP_OKAY;
      end else if (ar_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `MQ_RESP_OKAY;
         if (raddr == (ADDR_W-2)'(`MQ_CTRL_OFS >> 2)) begin
            s_axi_rdata <= ctrl;
         end else if (raddr == (ADDR_W-2)'(`MQ_STAT_OFS >> 2)) begin
            s_axi_rdata <= {22'h000000, !empty[Q_OUT_POST], ipn_status, full, empty};
         end else if (is_ptr(raddr)) begin
            s_axi_rdata <= {base, rd_pidx[0] ? top_ptr[rd_pidx[2:1]]
                                             : bot_ptr[rd_pidx[2:1]]};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MQ_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // PCI queue ports
   port_state_t ps;
   queue_t cur_q, q_sel;
   logic cur_wr;
   logic accept, port_hit, port_go, lb_done;
   logic [31:0] lb_start_addr;
   logic [3:0] dev_top_adv, dev_bot_adv;

   assign pci_req_ready = (ps == PS_IDLE);
   assign pci_rsp_valid = (ps == PS_RSP);
   assign accept = pci_req_valid && pci_req_ready;
   assign port_hit = msg_en && !pci_access_disable &&
                     (pci_req_offset == `MQ_PORT_IN || pci_req_offset == `MQ_PORT_OUT);
   always_comb begin
      if (pci_req_offset == `MQ_PORT_IN) begin
         q_sel = pci_req_write ? Q_IN_POST : Q_IN_FREE;
      end else begin
         q_sel = pci_req_write ? Q_OUT_FREE : Q_OUT_POST;
      end
   end
   // a full queue drops the write, an empty one answers without a bus cycle
   assign port_go = accept && port_hit && (pci_req_write ? !full[q_sel] : !empty[q_sel]);
   assign lb_start_addr = {base, pci_req_write ? top_ptr[q_sel] : bot_ptr[q_sel]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ps <= PS_IDLE;
      end else begin
         unique case (ps)
            PS_IDLE: if (accept) ps <= port_go ? PS_LB : PS_RSP;
            PS_LB: if (lb_done) ps <= PS_RSP;
            PS_RSP: ps <= PS_IDLE;
            default: ps <= PS_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cur_q <= Q_IN_FREE;
         cur_wr <= 1'b0;
         pci_rsp_rdata <= 32'h0000_0000;
      end else if (accept) begin
         cur_q <= q_sel;
         cur_wr <= pci_req_write;
         pci_rsp_rdata <= `MQ_EMPTY_DATA;
      end else if (ps == PS_LB && lb_done && !cur_wr) begin
         pci_rsp_rdata <= lb_rsp_rdata;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_int_pulse <= 2'b00;
      end else begin
         sys_int_pulse[0] <= accept && pci_req_write && msg_en && !pci_access_disable &&
                             pci_req_offset == `MQ_SYSINT0;
         sys_int_pulse[1] <= accept && pci_req_write && msg_en && !pci_access_disable &&
                             pci_req_offset == `MQ_SYSINT1;
      end
   end

   lb_cycle u_lb (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(port_go),
      .write(pci_req_write),
      .addr(lb_start_addr),
      .wdata(pci_req_wdata),
      .lb_req_valid(lb_req_valid),
      .lb_req_ready(lb_req_ready),
      .lb_req_write(lb_req_write),
      .lb_req_addr(lb_req_addr),
      .lb_req_wdata(lb_req_wdata),
      .lb_rsp_valid(lb_rsp_valid),
      .done(lb_done)
   );

   // pointers and full flags, one set per queue
   for (genvar q = 0; q < 4; q++) begin : g_queue
      logic sw_top, sw_bot, top_fills;
      logic [19:0] new_top, new_bot;
      queue_ptr_step u_top_step (.ptr(top_ptr[q]), .size_sel(size_sel), .next_ptr(top_next[q]));
      queue_ptr_step u_bot_step (.ptr(bot_ptr[q]), .size_sel(size_sel), .next_ptr(bot_next[q]));
      assign dev_top_adv[q] = ps == PS_LB && lb_done && cur_wr && cur_q == queue_t'(q);
      assign dev_bot_adv[q] = ps == PS_LB && lb_done && !cur_wr && cur_q == queue_t'(q);
      assign sw_top = wr_ptr && wr_pidx == 3'(2*q+1);
      assign sw_bot = wr_ptr && wr_pidx == 3'(2*q);
      assign new_top = sw_top ? ptr_wval[19:0] : dev_top_adv[q] ? top_next[q] : top_ptr[q];
      assign new_bot = sw_bot ? ptr_wval[19:0] : dev_bot_adv[q] ? bot_next[q] : bot_ptr[q];
      assign empty[q] = (top_ptr[q] == bot_ptr[q]) && !full[q];
      // only a one-entry step fills; setting top equal to bottom at start-up means empty
      assign top_fills = (dev_top_adv[q] && !sw_top) ||
                         (sw_top && ptr_wval[19:0] == top_next[q]);
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            top_ptr[q] <= 20'h00000;
            bot_ptr[q] <= 20'h00000;
         end else begin
            top_ptr[q] <= new_top;
            bot_ptr[q] <= new_bot;
         end
      end
      // a top that steps onto the bottom means full, even with a same-cycle bottom move; else any bottom move clears it
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            full[q] <= 1'b0;
         end else if (top_fills && new_top != top_ptr[q] && new_top == new_bot) begin
            full[q] <= 1'b1;
         end else if (new_bot != bot_ptr[q]) begin
            full[q] <= 1'b0;
         end
      end
   end

   // inbound post notice: a new post beats a same-cycle write-one clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ipn_status <= 1'b0;
      end else if (dev_top_adv[Q_IN_POST] && ipn_en) begin
         ipn_status <= 1'b1;
      end else if (wr_stat && s_axi_wstrb[1] && s_axi_wdata[`MQ_STAT_IPN]) begin
         ipn_status <= 1'b0;
      end
   end

   assign lb_irq = ipn_status;
   assign pci_irq = op_en && !empty[Q_OUT_POST];
   assign window_bar_cfg_offset = msg_en ? `MQ_CFG_BAR0 : `MQ_CFG_NONE;
   assign register_bar_cfg_offset = msg_en ? `MQ_CFG_BAR2 : `MQ_CFG_BAR0;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_quick_rsp;
      pci_rsp_valid && !lb_req_valid ##1 !pci_rsp_valid;
   endsequence

   sequence s_lb_started;
      lb_req_valid && lb_req_addr == $past(lb_start_addr);
   endsequence

   chk_empty_all_ones: assert property (
      accept && !pci_req_write && port_hit && empty[q_sel]
      |=> s_quick_rsp and pci_rsp_rdata == 32'hffff_ffff)
      else $error("empty queue read did not answer all ones at once");

   chk_full_write_drop: assert property (
      accept && pci_req_write && port_hit && full[q_sel] && !wr_ptr
      |=> ($stable(top_ptr[Q_IN_POST]) && $stable(top_ptr[Q_OUT_FREE])) ##0 s_quick_rsp)
      else $error("write to full queue was not dropped");

   chk_read_lb_addr: assert property (
      port_go && !pci_req_write |=> s_lb_started ##0 !lb_req_write)
      else $error("queue read did not start at the bottom pointer");

   chk_write_lb_data: assert property (
      port_go && pci_req_write
      |=> s_lb_started ##0 lb_req_write && lb_req_wdata == $past(pci_req_wdata))
      else $error("queue write did not start at the top pointer");

   chk_bottom_advance: assert property (
      dev_bot_adv[Q_IN_FREE] && !wr_ptr
      |=> bot_ptr[Q_IN_FREE] == $past(bot_next[Q_IN_FREE]) && pci_rsp_valid
      && pci_rsp_rdata == $past(lb_rsp_rdata))
      else $error("inbound free bottom did not advance with the answer");

   chk_wrap_window: assert property (
      (top_next[Q_OUT_FREE] & ~qmask) == (top_ptr[Q_OUT_FREE] & ~qmask)
      && top_next[Q_OUT_FREE][1:0] == top_ptr[Q_OUT_FREE][1:0])
      else $error("out free top left its queue on advance");

   chk_post_notice: assert property (
      dev_top_adv[Q_IN_POST] && ipn_en |=> lb_irq ##1 (lb_irq || $past(wr_stat)))
      else $error("inbound post did not raise the local interrupt");

   chk_notice_clear: assert property (
      wr_stat && s_axi_wstrb[1] && s_axi_wdata[`MQ_STAT_IPN] && !dev_top_adv[Q_IN_POST]
      |=> !lb_irq)
      else $error("write one did not clear the inbound post notice");

   chk_out_post_irq: assert property (
      wr_ptr && wr_pidx == 3'd5 && op_en && ptr_wval[19:0] != bot_ptr[Q_OUT_POST]
      && !dev_bot_adv[Q_OUT_POST] |=> pci_irq)
      else $error("posting to out post queue did not raise the PCI interrupt");

   chk_bar_swap: assert property (
      $rose(msg_en) |-> window_bar_cfg_offset == 8'h10 && register_bar_cfg_offset == 8'h18)
      else $error("messaging enable did not move the base registers");

   chk_startup_empty: assert property (
      $past(aresetn) == 1'b0 |-> empty == 4'hf && !pci_irq)
      else $error("queues not empty after reset");
endmodule : msgq_unit

// ---- dv/lb_mem_model.sv ----
// Purpose: local bus memory that holds the message queues
// Assumes: one request at a time, answered by one rsp pulse
// Notes: stall sets extra wait cycles before each answer
`timescale 1ns/100ps
module lb_mem_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] stall,
   input wire logic lb_req_valid,
   output logic lb_req_ready,
   input wire logic lb_req_write,
   input wire logic [31:0] lb_req_addr,
   input wire logic [31:0] lb_req_wdata,
   output logic lb_rsp_valid,
   output logic [31:0] lb_rsp_rdata
);
   logic [31:0] mem [logic [31:0]];
   logic busy;
   logic is_wr;
   logic [31:0] addr_q;
   logic [3:0] cnt;
   initial lb_rsp_rdata = 32'h0;
   always @(posedge aclk) begin
      lb_rsp_valid <= 1'b0;
      // data outside an answer keeps changing so stale values never match
      lb_rsp_rdata <= ~lb_rsp_rdata;
      if (!aresetn) begin
         lb_req_ready <= 1'b0;
         busy <= 1'b0;
      end else if (busy) begin
         if (cnt == 4'h0) begin
            busy <= 1'b0;
            lb_rsp_valid <= 1'b1;
            if (!is_wr) lb_rsp_rdata <= mem.exists(addr_q) ? mem[addr_q] : ~addr_q;
         end else begin
            cnt <= cnt - 4'h1;
         end
      end else if (lb_req_valid && lb_req_ready) begin
         lb_req_ready <= 1'b0;
         busy <= 1'b1;
         cnt <= stall;
         is_wr <= lb_req_write;
         addr_q <= lb_req_addr;
         if (lb_req_write) mem[lb_req_addr] = lb_req_wdata;
      end else begin
         lb_req_ready <= lb_req_valid;
      end
   end
endmodule : lb_mem_model

// ---- dv/msgq_unit_tb.sv ----
// Purpose: self-checking bench of the message queue unit
// Assumes: window base 0xa00, 1 Kbyte queues at 0x000/0x400/0x800/0xc00
// Notes: this bench plays the PCI agent and the local host
`timescale 1ns/100ps
`include "msgq_regs.svh"
module msgq_unit_tb import msgq_pkg::*;;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, pci_req_valid, pci_req_ready, pci_req_write;
   logic pci_rsp_valid, pci_irq, lb_irq, lb_req_valid, lb_req_ready, lb_req_write, lb_rsp_valid;
   logic [7:0] awaddr, araddr, win_bar, reg_bar;
   logic [3:0] wstrb, stall;
   logic [1:0] bresp, rresp, sys_int_pulse;
   logic [1:0] sys_seen = 2'b00;
   logic [11:0] pci_req_offset;
   logic [31:0] wdata, rdata, pci_req_wdata, pci_rsp_rdata, pci_rd, ax_rd;
   logic [31:0] lb_req_addr, lb_req_wdata, lb_rsp_rdata;
   logic [31:0] ptrs [8] = '{32'h0, 32'h8, 32'h400, 32'h400, 32'h800, 32'h800, 32'hc00, 32'hffc};
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int lb_cnt = 0;
   msgq_unit #(.ADDR_W(8)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pci_req_valid(pci_req_valid), .pci_req_ready(pci_req_ready),
      .pci_req_write(pci_req_write), .pci_req_offset(pci_req_offset),
      .pci_req_wdata(pci_req_wdata), .pci_rsp_valid(pci_rsp_valid),
      .pci_rsp_rdata(pci_rsp_rdata), .sys_int_pulse(sys_int_pulse), .pci_irq(pci_irq),
      .lb_irq(lb_irq), .window_bar_cfg_offset(win_bar), .register_bar_cfg_offset(reg_bar),
      .lb_req_valid(lb_req_valid), .lb_req_ready(lb_req_ready), .lb_req_write(lb_req_write),
      .lb_req_addr(lb_req_addr), .lb_req_wdata(lb_req_wdata), .lb_rsp_valid(lb_rsp_valid),
      .lb_rsp_rdata(lb_rsp_rdata));
   lb_mem_model lb (.aclk(aclk), .aresetn(aresetn), .stall(stall),
      .lb_req_valid(lb_req_valid), .lb_req_ready(lb_req_ready), .lb_req_write(lb_req_write),
      .lb_req_addr(lb_req_addr), .lb_req_wdata(lb_req_wdata), .lb_rsp_valid(lb_rsp_valid),
      .lb_rsp_rdata(lb_rsp_rdata));
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      sys_seen <= sys_seen | sys_int_pulse;
      if (lb_req_valid === 1'b1 && lb_req_ready === 1'b1) lb_cnt++;
      if (cyc == 5000) begin
         bad_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         input logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      check({30'h0, bresp}, {30'h0, r});
      @(posedge aclk);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      ax_rd = rdata;
      check({30'h0, rresp}, {30'h0, r});
      @(posedge aclk);
   endtask : axi_rd
   task automatic pci(input logic w, input logic [11:0] o, input logic [31:0] d);
      pci_req_valid <= 1'b1;
      pci_req_write <= w;
      pci_req_offset <= o;
      pci_req_wdata <= d;
      do @(posedge aclk); while (pci_req_ready !== 1'b1);
      pci_req_valid <= 1'b0;
      do @(posedge aclk); while (pci_rsp_valid !== 1'b1);
      pci_rd = pci_rsp_rdata;
   endtask : pci
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, pci_req_valid, pci_req_write} = 7'h0;
      {awaddr, araddr, wstrb, stall, pci_req_offset} = 36'h0;
      {wdata, pci_req_wdata} = 64'h0;
      lb.mem[32'ha000_0000] = 32'h0000_1000;
      lb.mem[32'ha000_0004] = 32'h0000_2000;
      lb.mem[32'ha000_0800] = 32'h0000_5000;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(`MQ_CTRL_OFS, `MQ_RESP_OKAY);
      check(ax_rd, `MQ_CTRL_RST);
      axi_rd(`MQ_STAT_OFS, `MQ_RESP_OKAY);
      check(ax_rd, 32'h0000_000f);
      check({16'h0, win_bar, reg_bar}, {16'h0, `MQ_CFG_NONE, `MQ_CFG_BAR0});
      axi_rd(8'h08, `MQ_RESP_SLVERR);
      axi_wr(8'h30, 32'h0, 4'hf, `MQ_RESP_SLVERR);
      pci(1'b0, `MQ_PORT_IN, 32'h0);
      check(pci_rd, `MQ_EMPTY_DATA);
      check(lb_cnt, 0);
      $display("test reset and map done");
      for (int i = 0; i < 8; i++) axi_wr(8'(`MQ_PTR_OFS + 4 * i), ptrs[i], 4'hf, 2'b00);
      axi_wr(`MQ_CTRL_OFS, 32'ha000_000d, 4'hf, `MQ_RESP_OKAY);
      axi_rd(8'h14, `MQ_RESP_OKAY);
      check(ax_rd, 32'ha000_0008);
      check({16'h0, win_bar, reg_bar}, {16'h0, `MQ_CFG_BAR0, `MQ_CFG_BAR2});
      $display("test setup done");
      stall <= 4'h3;
      pci(1'b0, `MQ_PORT_IN, 32'h0);
      check(pci_rd, 32'h0000_1000);
      axi_rd(8'h10, `MQ_RESP_OKAY);
      check(ax_rd, 32'ha000_0004);
      pci(1'b0, `MQ_PORT_IN, 32'h0);
      check(pci_rd, 32'h0000_2000);
      pci(1'b0, `MQ_PORT_IN, 32'h0);
      check(pci_rd, `MQ_EMPTY_DATA);
      check(lb_cnt, 2);
      axi_rd(8'h10, `MQ_RESP_OKAY);
      check(ax_rd, 32'ha000_0008);
      pci(1'b1, `MQ_PORT_IN, 32'h0000_3000);
      check(lb.mem[32'ha000_0400], 32'h0000_3000);
      axi_rd(8'h1c, `MQ_RESP_OKAY);
      check(ax_rd, 32'ha000_0404);
      check(lb_irq, 1'b1);
      axi_rd(`MQ_STAT_OFS, `MQ_RESP_OKAY);
      check(ax_rd, 32'h0000_0105);
      axi_wr(`MQ_STAT_OFS, 32'h0000_0100, 4'h1, `MQ_RESP_OKAY);
      check(lb_irq, 1'b1);
      axi_wr(`MQ_STAT_OFS, 32'h0000_0100, 4'h2, `MQ_RESP_OKAY);
      check(lb_irq, 1'b0);
      $display("test inbound done");
      stall <= 4'h0;
      check(pci_irq, 1'b0);
      axi_wr(8'h24, 32'h0000_0804, 4'hf, `MQ_RESP_OKAY);
      check(pci_irq, 1'b1);
      pci(1'b0, `MQ_PORT_OUT, 32'h0);
      check(pci_rd, 32'h0000_5000);
      axi_rd(8'h20, `MQ_RESP_OKAY);
      check(ax_rd, 32'ha000_0804);
      check(pci_irq, 1'b0);
      pci(1'b0, `MQ_PORT_OUT, 32'h0);
      check(pci_rd, `MQ_EMPTY_DATA);
      $display("test outbound done");
      pci(1'b1, `MQ_PORT_OUT, 32'h0000_7000);
      check(lb.mem[32'ha000_0ffc], 32'h0000_7000);
      axi_rd(8'h2c, `MQ_RESP_OKAY);
      check(ax_rd, 32'ha000_0c00);
      axi_rd(`MQ_STAT_OFS, `MQ_RESP_OKAY);
      check(ax_rd, 32'h0000_0085);
      pci(1'b1, `MQ_PORT_OUT, 32'h0000_8000);
      check(lb_cnt, 5);
      axi_rd(8'h2c, `MQ_RESP_OKAY);
      check(ax_rd, 32'ha000_0c00);
      $display("test wrap and full done");
      pci(1'b1, `MQ_SYSINT0, 32'h1);
      @(posedge aclk);
      check(sys_seen, 2'b01);
      pci(1'b1, `MQ_SYSINT1, 32'h1);
      @(posedge aclk);
      check(sys_seen, 2'b11);
      pci(1'b0, `MQ_SYSINT0, 32'h0);
      check(pci_rd, `MQ_EMPTY_DATA);
      $display("test system interrupts done");
      end_sim();
   end
endmodule : msgq_unit_tb
